// ---- design/sgc_top.sv ----
// Global control bits of the switch: registers, straps and the frame decisions they steer
//
// How it works
// RL1: Size check clear: frames up to 1536 bytes are accepted; reset from strap.
// RL2: Size check set: drop tagged frames over 1522, untagged over 1518.
// RL3: Huge frame bit accepts frames up to 1916 bytes, overriding size check.
// RL4: Buffer reserve bit set (reset one) holds 48 buffers per port for high priority.
// RL5: Software should set buffer reserve whenever priority queueing is on.
// RL6: VLAN forwarding applies only while the VLAN bit is set; resets off.
// RL7: Software fills the VLAN table before setting the VLAN bit.
// RL8: IGMP snoop bit forwards every IGMP frame that is not dropped for size to the switch MII; resets off.
// RL9: Scheme field: 00 strict, 01 ten to one, 10 five to one, 11 two to one.
// RL10: Sniff mode one needs both ports to match; zero needs either.
// RL11: For receive-only mirroring software keeps sniff mode at zero.
// RL12: Software writes reserved bits with their defaults and never changes them.
// RL13: MII duplex bit one is half duplex, zero is full duplex.
// RL14: MII duplex reset value comes from its strap pin, pull-down means full.
// RL15: Writes act on later frames with no chip reset needed.
`timescale 1ns/1ps
`include "sgc_map.svh"

module sgc_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Strap pins, sampled while in reset
   input wire logic size_check_strap_pin,
   input wire logic mii_duplex_strap_pin,
   // Management register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   output logic reg_rvalid_q,
   // Received frame length check
   input wire logic frm_valid,
   input wire logic [10:0] frm_len,
   input wire logic frm_tagged,
   input wire logic frm_is_igmp,
   output logic frm_done_q,
   output logic frm_drop_q,
   output logic frm_to_mii_q,
   // Port mirroring
   input wire logic sniff_valid,
   input wire logic sniff_src_match,
   input wire logic sniff_dst_match,
   output logic sniff_mirror_q,
   // Egress scheduling
   input wire logic hi_pending,
   input wire logic lo_pending,
   input wire logic grant_req,
   output logic grant_hi_q,
   output logic grant_lo_q,
   // Static controls to forwarding, queueing and MII
   output logic vlan_en_q,
   output logic [5:0] prio_bufs_q,
   output logic mii_half_duplex_q,
   output logic ready_q
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   sgc_pkg::sgc_init_e st_q;
   sgc_pkg::sgc_init_e st_d;
   logic size_strap;
   logic dup_strap;

   logic huge_q;
   logic huge_d;
   logic legal_q;
   logic legal_d;
   logic prio_rsv_q;
   logic prio_rsv_d;
   logic [7:0] ctrl3_q;
   logic [7:0] ctrl3_d;
   logic c4_rsv7_q;
   logic c4_rsv7_d;
   logic half_dup_q;
   logic half_dup_d;

   logic [7:0] rdata_d;
   logic rvalid_d;
   logic [10:0] len_limit;
   logic frm_done_d;
   logic frm_drop_d;
   logic frm_to_mii_d;
   logic sniff_mirror_d;

   // Next values of the static control outputs
   logic vlan_en_d;
   logic [5:0] prio_bufs_d;
   logic mii_half_duplex_d;
   logic ready_d;

   ////////////////////////////////////////////////////////////////////////
   // Strap synchronisers
   // Straps are only looked at on the first edge after release; a pin that moves later has no effect

   sgc_sync2 u_sync_size (
      .clk_sys(clk_sys),
      .pin(size_check_strap_pin),
      .level(size_strap)
   );

   sgc_sync2 u_sync_dup (
      .clk_sys(clk_sys),
      .pin(mii_duplex_strap_pin),
      .level(dup_strap)
   );

   ////////////////////////////////////////////////////////////////////////
   // Start-up: the first edge after release loads the straps, then run
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         sgc_pkg::SGC_ST_STRAP:
            st_d = sgc_pkg::SGC_ST_RUN;
         sgc_pkg::SGC_ST_RUN:
            st_d = sgc_pkg::SGC_ST_RUN;
         default:
            st_d = sgc_pkg::SGC_ST_STRAP;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes; the strap load wins over a write in the same cycle
   always_comb
   begin
      huge_d = huge_q;
      legal_d = legal_q;
      prio_rsv_d = prio_rsv_q;
      ctrl3_d = ctrl3_q;
      c4_rsv7_d = c4_rsv7_q;
      half_dup_d = half_dup_q;
      if (st_q == sgc_pkg::SGC_ST_STRAP)
      begin
         legal_d = size_strap; // [RL1]
         half_dup_d = dup_strap; // [RL14]
      end
      else if (reg_wr)
      begin
         // New values feed the frame logic on the next edge [RL15]
         if (reg_addr == `SGC_OFF_CTRL_TWO)
         begin
            huge_d = reg_wdata[`SGC_C2_HUGE];
            legal_d = reg_wdata[`SGC_C2_LEGAL];
            prio_rsv_d = reg_wdata[`SGC_C2_PRIO_RSV];
         end
         else if (reg_addr == `SGC_OFF_CTRL_THREE)
         begin
            // Reserved bits stored as written; software keeps the defaults [RL12]
            ctrl3_d = reg_wdata;
         end
         else if (reg_addr == `SGC_OFF_CTRL_FOUR)
         begin
            c4_rsv7_d = reg_wdata[`SGC_C4_RSV7];
            half_dup_d = reg_wdata[`SGC_C4_HALF_DUP];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read-back, one cycle after the strobe; fields outside this block read zero
   always_comb
   begin
      rdata_d = 8'h00;
      rvalid_d = reg_rd;
      if (reg_rd)
      begin
         if (reg_addr == `SGC_OFF_CTRL_TWO)
         begin
            rdata_d[`SGC_C2_HUGE] = huge_q;
            rdata_d[`SGC_C2_LEGAL] = legal_q;
            rdata_d[`SGC_C2_PRIO_RSV] = prio_rsv_q;
         end
         else if (reg_addr == `SGC_OFF_CTRL_THREE)
            rdata_d = ctrl3_q;
         else if (reg_addr == `SGC_OFF_CTRL_FOUR)
         begin
            rdata_d[`SGC_C4_RSV7] = c4_rsv7_q;
            rdata_d[`SGC_C4_HALF_DUP] = half_dup_q;
         end
         else
            rdata_d = 8'h00; // Unmapped offsets read zero
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Largest legal frame for the current settings
   always_comb
   begin
      if (huge_q)
         len_limit = `SGC_LEN_HUGE; // [RL3]
      else if (legal_q && frm_tagged)
         len_limit = `SGC_LEN_TAGGED; // [RL2]
      else if (legal_q)
         len_limit = `SGC_LEN_UNTAGGED; // [RL2]
      else
         len_limit = `SGC_LEN_ANY; // [RL1]
   end

   // Per-frame verdicts; limits are inclusive
   always_comb
   begin
      frm_done_d = frm_valid;
      frm_drop_d = 1'b0;
      frm_to_mii_d = 1'b0;
      if (frm_valid)
      begin
         frm_drop_d = (frm_len > len_limit); // [RL1] [RL2] [RL3]
         // A dropped frame is never snooped
         frm_to_mii_d = ctrl3_q[`SGC_C3_IGMP] && frm_is_igmp && (frm_len <= len_limit); // [RL8]
      end
   end

   // Mirroring match: AND mode needs both ports, OR mode either one
   always_comb
   begin
      sniff_mirror_d = 1'b0;
      if (sniff_valid)
      begin
         if (ctrl3_q[`SGC_C3_SNIFF])
            sniff_mirror_d = sniff_src_match && sniff_dst_match; // [RL10]
         else
            sniff_mirror_d = sniff_src_match || sniff_dst_match; // [RL10] [RL11]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Static controls, worked out from the next register values
   // They change at the very edge that takes a write, and leave straight from flip-flops
   // so forwarding and queueing logic never sees a decode glitch
   always_comb
   begin
      vlan_en_d = ctrl3_d[`SGC_C3_VLAN]; // [RL6] [RL7]
      prio_bufs_d = 6'h00; // Nothing held back
      if (prio_rsv_d)
         prio_bufs_d = `SGC_PRIO_BUFS; // [RL4] [RL5]
      mii_half_duplex_d = half_dup_d; // [RL13]
      ready_d = (st_d == sgc_pkg::SGC_ST_RUN);
   end

   ////////////////////////////////////////////////////////////////////////
   // Egress scheduler driven by the scheme field
   sgc_sched u_sched (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .scheme(ctrl3_q[`SGC_C3_PRIO_HI:`SGC_C3_PRIO_LO]), // [RL9]
      .hi_pending(hi_pending),
      .lo_pending(lo_pending),
      .grant_req(grant_req),
      .grant_hi_q(grant_hi_q),
      .grant_lo_q(grant_lo_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Registers; strapped bits take a safe constant until the strap load
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q <= sgc_pkg::SGC_ST_STRAP;
         huge_q <= `SGC_RST_HUGE;
         legal_q <= `SGC_RST_STRAPPED;
         prio_rsv_q <= `SGC_RST_PRIO_RSV; // [RL4]
         ctrl3_q <= `SGC_RST_CTRL_THREE; // [RL6] [RL8] [RL9] [RL10]
         c4_rsv7_q <= `SGC_RST_C4_RSV7;
         half_dup_q <= `SGC_RST_STRAPPED;
         reg_rdata_q <= 8'h00;
         reg_rvalid_q <= 1'b0;
         frm_done_q <= 1'b0;
         frm_drop_q <= 1'b0;
         frm_to_mii_q <= 1'b0;
         sniff_mirror_q <= 1'b0;
         vlan_en_q <= 1'b0;
         prio_bufs_q <= 6'h00;
         mii_half_duplex_q <= 1'b0;
         ready_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         huge_q <= huge_d;
         legal_q <= legal_d;
         prio_rsv_q <= prio_rsv_d;
         ctrl3_q <= ctrl3_d;
         c4_rsv7_q <= c4_rsv7_d;
         half_dup_q <= half_dup_d;
         reg_rdata_q <= rdata_d;
         reg_rvalid_q <= rvalid_d;
         frm_done_q <= frm_done_d;
         frm_drop_q <= frm_drop_d;
         frm_to_mii_q <= frm_to_mii_d;
         sniff_mirror_q <= sniff_mirror_d;
         vlan_en_q <= vlan_en_d;
         prio_bufs_q <= prio_bufs_d;
         mii_half_duplex_q <= mii_half_duplex_d;
         ready_q <= ready_d;
      end
   end

endmodule

// ---- common/sgc_map.svh ----
// Register offsets, field positions, reset values and size limits of the global control bits
`ifndef SGC_MAP_SVH
`define SGC_MAP_SVH

// Register offsets on the management register port
`define SGC_OFF_CTRL_TWO 8'h04
`define SGC_OFF_CTRL_THREE 8'h05
`define SGC_OFF_CTRL_FOUR 8'h06

// Control two, low bits
`define SGC_C2_HUGE 2
`define SGC_C2_LEGAL 1
`define SGC_C2_PRIO_RSV 0

// Control three
`define SGC_C3_VLAN 7
`define SGC_C3_IGMP 6
`define SGC_C3_RSV5 5
`define SGC_C3_RSV4 4
`define SGC_C3_PRIO_HI 3
`define SGC_C3_PRIO_LO 2
`define SGC_C3_RSV1 1
`define SGC_C3_SNIFF 0

// Control four, upper bits
`define SGC_C4_RSV7 7
`define SGC_C4_HALF_DUP 6

// Reset values of the non-strapped bits
`define SGC_RST_HUGE 1'b0
`define SGC_RST_PRIO_RSV 1'b1
`define SGC_RST_CTRL_THREE 8'h00
`define SGC_RST_C4_RSV7 1'b0

// Strapped bits hold this until the strap load on the first edge after release
`define SGC_RST_STRAPPED 1'b0

// Frame size limits in bytes
`define SGC_LEN_ANY 11'h600
`define SGC_LEN_TAGGED 11'h5f2
`define SGC_LEN_UNTAGGED 11'h5ee
`define SGC_LEN_HUGE 11'h77c

// Buffers held back per port for high priority frames
`define SGC_PRIO_BUFS 6'h30

// High to low grant ratios
`define SGC_RATIO_10 4'ha
`define SGC_RATIO_5 4'h5
`define SGC_RATIO_2 4'h2

`endif

// ---- common/sgc_pkg.sv ----
// Types shared by the global control bits design
package sgc_pkg;

   // Egress priority scheme codes
   typedef enum logic [1:0] {
      SGC_PRIO_STRICT = 2'h0,
      SGC_PRIO_R10 = 2'h1,
      SGC_PRIO_R5 = 2'h2,
      SGC_PRIO_R2 = 2'h3
   } sgc_prio_e;

   // Start-up sequence, one-hot
   typedef enum logic [1:0] {
      SGC_ST_STRAP = 2'b01,
      SGC_ST_RUN = 2'b10
   } sgc_init_e;

   // Scheduler grant state, one-hot
   typedef enum logic [1:0] {
      SGC_GR_IDLE = 2'b01,
      SGC_GR_BUSY = 2'b10
   } sgc_grant_e;

endpackage

// ---- design/sgc_sync2.sv ----
// Two-stage synchroniser for a strap pin
`timescale 1ns/1ps
`include "sgc_map.svh"

module sgc_sync2 (
   // Clock
   input wire logic clk_sys,
   // Asynchronous level in, synchronised level out
   input wire logic pin,
   output logic level
);

   logic meta_q;
   logic sync_q;

   ////////////////////////////////////////////////////////////////////////
   // No reset here on purpose: the straps must be sampled while rstn is low
   always_ff @(posedge clk_sys)
   begin
      meta_q <= pin;
      sync_q <= meta_q;
   end

   assign level = sync_q;

endmodule

// ---- design/sgc_sched.sv ----
// Egress high/low priority grant scheduler
`timescale 1ns/1ps
`include "sgc_map.svh"

module sgc_sched (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Scheme select
   input wire logic [1:0] scheme,
   // Queue state and grant request
   input wire logic hi_pending,
   input wire logic lo_pending,
   input wire logic grant_req,
   // Grants, one-cycle pulses
   output logic grant_hi_q,
   output logic grant_lo_q
);

   logic [3:0] hi_cnt_q;
   logic [3:0] hi_cnt_d;
   logic grant_hi_d;
   logic grant_lo_d;
   logic [3:0] ratio;
   sgc_pkg::sgc_grant_e st_q;
   sgc_pkg::sgc_grant_e st_d;

   ////////////////////////////////////////////////////////////////////////
   // Ratio for the selected scheme; strict mode never forces a low grant
   always_comb
   begin
      if (scheme == sgc_pkg::SGC_PRIO_R10)
         ratio = `SGC_RATIO_10;
      else if (scheme == sgc_pkg::SGC_PRIO_R5)
         ratio = `SGC_RATIO_5;
      else if (scheme == sgc_pkg::SGC_PRIO_R2)
         ratio = `SGC_RATIO_2;
      else
         ratio = 4'h0;
   end

   // Low queue is served once ratio high grants have gone out
   always_comb
   begin
      hi_cnt_d = hi_cnt_q;
      grant_hi_d = 1'b0;
      grant_lo_d = 1'b0;
      st_d = st_q;
      case (st_q)
         sgc_pkg::SGC_GR_IDLE:
         begin
            if (grant_req)
               st_d = sgc_pkg::SGC_GR_BUSY;
         end
         sgc_pkg::SGC_GR_BUSY:
         begin
            st_d = sgc_pkg::SGC_GR_IDLE;
            if (hi_pending && (ratio == 4'h0 || hi_cnt_q < ratio || !lo_pending))
            begin
               grant_hi_d = 1'b1;
               if (hi_cnt_q < ratio)
                  hi_cnt_d = hi_cnt_q + 4'h1;
            end
            else if (lo_pending)
            begin
               grant_lo_d = 1'b1;
               hi_cnt_d = 4'h0;
            end
         end
         default:
            st_d = sgc_pkg::SGC_GR_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q <= sgc_pkg::SGC_GR_IDLE;
         hi_cnt_q <= 4'h0;
         grant_hi_q <= 1'b0;
         grant_lo_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         hi_cnt_q <= hi_cnt_d;
         grant_hi_q <= grant_hi_d;
         grant_lo_q <= grant_lo_d;
      end
   end

endmodule

// ---- verif/sgc_top_props.sv ----
// Concurrent checks on the ports of the global control bits
`timescale 1ns/1ps
module sgc_top_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Strap and register port
   input wire logic mii_duplex_strap_pin,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   // Frame check and mirroring
   input wire logic frm_valid,
   input wire logic [10:0] frm_len,
   input wire logic frm_is_igmp,
   input wire logic frm_done_q,
   input wire logic frm_drop_q,
   input wire logic frm_to_mii_q,
   input wire logic sniff_valid,
   input wire logic sniff_src_match,
   input wire logic sniff_dst_match,
   input wire logic sniff_mirror_q,
   // Scheduling and static controls
   input wire logic hi_pending,
   input wire logic grant_hi_q,
   input wire logic grant_lo_q,
   input wire logic vlan_en_q,
   input wire logic [5:0] prio_bufs_q,
   input wire logic mii_half_duplex_q,
   input wire logic ready_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////
   // Writes count only once the strap load is over, as it wins edge 1
   sequence wr2_s; reg_wr && reg_addr == 8'h04 && ready_q; endsequence
   sequence wr3_s; reg_wr && reg_addr == 8'h05 && ready_q; endsequence
   sequence wr4_s; reg_wr && reg_addr == 8'h06 && ready_q; endsequence
   wr_vlan_a: assert property (wr3_s |=> vlan_en_q == $past(reg_wdata[7]))
      else $error("vlan enable does not follow write");
   wr_bufs_a: assert property (wr2_s |=> prio_bufs_q == ($past(reg_wdata[0]) ? 6'h30 : 6'h00))
      else $error("reserved buffer count wrong after write");
   wr_duplex_a: assert property (wr4_s |=> mii_half_duplex_q == $past(reg_wdata[6]))
      else $error("duplex does not follow write");
   strap_load_a: assert property ($rose(ready_q) |-> mii_half_duplex_q == mii_duplex_strap_pin)
      else $error("duplex not loaded from strap");
   short_keep_a: assert property (frm_valid && frm_len <= 11'h5ee |=> frm_done_q && !frm_drop_q)
      else $error("short frame dropped");
   huge_drop_a: assert property (frm_valid && frm_len > 11'h77c |=> frm_done_q && frm_drop_q)
      else $error("oversize frame kept");
   igmp_copy_a: assert property (frm_to_mii_q |-> $past(frm_is_igmp) && frm_done_q && !frm_drop_q)
      else $error("copy to mii without cause");
   sniff_both_a: assert property (sniff_valid && sniff_src_match && sniff_dst_match |=> sniff_mirror_q)
      else $error("full match not mirrored");
   sniff_none_a: assert property (sniff_valid && !sniff_src_match && !sniff_dst_match |=> !sniff_mirror_q)
      else $error("no match but mirrored");
   grant_hi_a: assert property (grant_hi_q |-> !grant_lo_q && $past(hi_pending))
      else $error("high grant without cause");
endmodule

// ---- verif/switch_global_control_bits_test.sv ----
// Self-checking bench for the global control bits
`timescale 1ns/1ps
module switch_global_control_bits_test;
   logic clk_sys, rstn, size_check_strap_pin, mii_duplex_strap_pin, reg_wr, reg_rd, reg_rvalid_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
   logic frm_valid, frm_tagged, frm_is_igmp, frm_done_q, frm_drop_q, frm_to_mii_q;
   logic [10:0] frm_len;
   logic sniff_valid, sniff_src_match, sniff_dst_match, sniff_mirror_q;
   logic hi_pending, lo_pending, grant_req, grant_hi_q, grant_lo_q;
   logic vlan_en_q, mii_half_duplex_q, ready_q, huge_b, legal_b, snoop_b, gh, gl, synced;
   logic [5:0] prio_bufs_q;
   logic [10:0] lens [8] = '{11'h5ee, 11'h5ef, 11'h5f2, 11'h5f3, 11'h600, 11'h601, 11'h77c, 11'h77d};
   int miscompares, n_checks, seed, i, j, k, r, cnt;
   sgc_top u_sgc_top (.clk_sys, .rstn, .size_check_strap_pin, .mii_duplex_strap_pin, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .frm_valid, .frm_len, .frm_tagged, .frm_is_igmp,
      .frm_done_q, .frm_drop_q, .frm_to_mii_q, .sniff_valid, .sniff_src_match, .sniff_dst_match,
      .sniff_mirror_q, .hi_pending, .lo_pending, .grant_req, .grant_hi_q, .grant_lo_q, .vlan_en_q,
      .prio_bufs_q, .mii_half_duplex_q, .ready_q);
   // 10 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Inputs move 10 ns after the edge so no race with the design
   task automatic step;
      @(posedge clk_sys);
      #10;
   endtask
   // Each access starts with a step, so a strobe is never lowered and raised in one time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      step;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      step;
      reg_addr = a;
      reg_rd = 1'b1;
      step;
      reg_rd = 1'b0;
      chk("rvalid", reg_rvalid_q, 8'h01);
      chk("rdata", reg_rdata_q, exp);
   endtask
   // Size limit from the current huge and check bits
   function automatic logic exp_drop(input logic [10:0] len, input logic tag);
      return len > (huge_b ? 11'h77c : legal_b ? (tag ? 11'h5f2 : 11'h5ee) : 11'h600);
   endfunction
   task automatic frm(input logic [10:0] len, input logic tag, input logic igmp);
      step;
      frm_len = len;
      frm_tagged = tag;
      frm_is_igmp = igmp;
      frm_valid = 1'b1;
      step;
      frm_valid = 1'b0;
      chk("done", frm_done_q, 8'h01);
      chk("drop", frm_drop_q, exp_drop(len, tag));
      chk("to_mii", frm_to_mii_q, igmp & snoop_b & ~exp_drop(len, tag));
   endtask
   task automatic snf(input logic mode, input logic s, input logic d);
      step;
      sniff_src_match = s;
      sniff_dst_match = d;
      sniff_valid = 1'b1;
      step;
      sniff_valid = 1'b0;
      chk("mirror", sniff_mirror_q, mode ? s & d : s | d);
   endtask
   // Grant pulse stands for the one cycle after the decide edge
   task automatic gnt;
      step;
      grant_req = 1'b1;
      step;
      grant_req = 1'b0;
      step;
      gh = grant_hi_q;
      gl = grant_lo_q;
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      seed = 32'h03e0;
      {rstn, reg_wr, reg_rd, frm_valid, frm_tagged, frm_is_igmp, sniff_valid, grant_req} = '0;
      {sniff_src_match, sniff_dst_match, hi_pending, lo_pending, reg_addr, reg_wdata, frm_len} = '0;
      size_check_strap_pin = 1'b1;
      mii_duplex_strap_pin = 1'b1;
      repeat (8) @(posedge clk_sys);
      #10 rstn = 1'b1;
      for (i = 0; i < 20 && ready_q !== 1'b1; i++)
         step;
      chk("ready", ready_q, 8'h01);
      chk("half_dup", mii_half_duplex_q, 8'h01);
      chk("bufs", prio_bufs_q, 8'h30);
      rd(8'h04, 8'h03);
      rd(8'h05, 8'h00);
      rd(8'h06, 8'h40);
      rd(8'h20, 8'h00);
      $display("reset values done");
      // Every huge and check setting over the boundary lengths, then random lengths
      snoop_b = 1'b0;
      for (j = 0; j < 4; j++)
      begin
         {huge_b, legal_b} = j[1:0];
         wr(8'h04, {5'h00, huge_b, legal_b, 1'b1});
         for (i = 0; i < 16; i++)
            frm(lens[i / 2], i[0], 1'b0);
         repeat (8)
         begin
            k = $random(seed);
            frm(11'h400 + {1'b0, k[9:0]}, k[10], k[11]);
         end
      end
      $display("size limits done");
      wr(8'h05, 8'h40);
      snoop_b = 1'b1;
      frm(11'h064, 1'b0, 1'b1);
      frm(11'h77d, 1'b1, 1'b1);
      wr(8'h05, 8'h80);
      snoop_b = 1'b0;
      frm(11'h064, 1'b0, 1'b1);
      chk("vlan", vlan_en_q, 8'h01);
      rd(8'h05, 8'h80);
      wr(8'h05, 8'h00);
      chk("vlan", vlan_en_q, 8'h00);
      wr(8'h04, 8'h06);
      chk("bufs", prio_bufs_q, 8'h00);
      rd(8'h04, 8'h06);
      wr(8'h06, 8'h3f);
      chk("half_dup", mii_half_duplex_q, 8'h00);
      rd(8'h06, 8'h00);
      wr(8'h06, 8'h40);
      chk("half_dup", mii_half_duplex_q, 8'h01);
      $display("controls done");
      for (j = 0; j < 2; j++)
      begin
         wr(8'h05, {7'h00, j[0]});
         for (i = 0; i < 4; i++)
            snf(j[0], i[1], i[0]);
      end
      $display("sniff done");
      // Reserve stays on while priority queueing is used
      wr(8'h04, 8'h07);
      {hi_pending, lo_pending} = 2'b11;
      for (j = 0; j < 4; j++)
      begin
         wr(8'h05, {4'h0, j[1:0], 2'b00});
         r = (j == 1) ? 10 : (j == 2) ? 5 : 2;
         synced = (j == 0);
         cnt = 0;
         for (i = 0; i < 3 * (r + 1); i++)
         begin
            gnt;
            if (synced)
               chk("grant_lo", gl, (j != 0 && cnt == r) ? 8'h01 : 8'h00);
            chk("grant_hi", gh, {7'h00, ~gl});
            cnt = gl ? 0 : cnt + 1;
            synced = synced | gl;
         end
         chk("synced", synced, 8'h01);
      end
      hi_pending = 1'b0;
      gnt;
      chk("grant_lo", {gh, gl}, 8'h01);
      lo_pending = 1'b0;
      gnt;
      chk("no_grant", {gh, gl}, 8'h00);
      $display("scheduler done");
      // Second reset with both straps low: size check off, full duplex
      size_check_strap_pin = 1'b0;
      mii_duplex_strap_pin = 1'b0;
      rstn = 1'b0;
      repeat (4) step;
      chk("ready_rst", ready_q, 8'h00);
      chk("bufs_rst", prio_bufs_q, 8'h00);
      rstn = 1'b1;
      step;
      chk("ready", ready_q, 8'h01);
      chk("half_dup", mii_half_duplex_q, 8'h00);
      rd(8'h04, 8'h01);
      rd(8'h06, 8'h00);
      {huge_b, legal_b, snoop_b} = 3'b000;
      frm(11'h600, 1'b0, 1'b0);
      frm(11'h601, 1'b1, 1'b0);
      $display("second reset done");
      complete_run;
   end
   // Watchdog far beyond the expected run length
   initial
   begin
      #1_000_000;
      miscompares++;
      complete_run;
   end
endmodule
bind sgc_top sgc_top_props u_sgc_top_props (.clk_sys, .rstn, .mii_duplex_strap_pin, .reg_addr, .reg_wr,
   .reg_wdata, .frm_valid, .frm_len, .frm_is_igmp, .frm_done_q, .frm_drop_q, .frm_to_mii_q, .sniff_valid,
   .sniff_src_match, .sniff_dst_match, .sniff_mirror_q, .hi_pending, .grant_hi_q, .grant_lo_q, .vlan_en_q,
   .prio_bufs_q, .mii_half_duplex_q, .ready_q);
